// file: rtl/flw_top_entry_walker.sv
// Top-level entry walker for first-level translation, with AHB-Lite registers.
// Assumes one memory port that holds a locked read-modify-write while
// mem_lock is high, and a single AHB-Lite master on hclk.
`timescale 1ns/1ps
`default_nettype none
module flw_top_entry_walker #(
    parameter int ADDR_WIDTH = 48,
    parameter logic EXT_ACC_SUP = 1'b1,
    parameter logic HUGE_PAGES = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    output logic mem_req,
    output logic mem_we,
    output logic mem_lock,
    output logic [63:0] mem_addr,
    output logic [63:0] mem_wdata,
    output logic [1:0] mem_type,
    input wire logic [63:0] mem_rdata,
    input wire logic mem_ack,
    output logic walk_valid,
    output logic walk_fault,
    output logic [63:0] next_table_addr,
    output logic next_is_guest_phys,
    output logic [1:0] next_mem_type,
    output logic perm_exec,
    output logic perm_user,
    output logic perm_user_write,
    output logic perm_sup_write,
    output logic huge_page_support
);

    // Register state.
    logic [flw_pkg::CTRL_W-1:0] ctrl_q; // Context controls.
    logic [63:0] root_q; // Root pointer, bits 11:5 and 2:0 kept zero.
    logic [flw_pkg::RQ_INDEX_W-1:0] index_q; // Entry index.
    logic [31:0] result_q; // Outcome of the last walk.
    logic [flw_pkg::INT_W-1:0] int_status_q; // Sticky events.
    logic [flw_pkg::INT_W-1:0] int_mask_q; // Event enables.
    logic [63:0] entry_q; // Fetched entry.
    flw_pkg::flw_state_t state_q; // Walker state.
    flw_pkg::flw_state_t state_d;

    // Bus pipeline state.
    logic wr_pend_q; // A write data phase is in progress.
    logic rd_pend_q; // A read is in its wait cycle.
    logic [flw_pkg::ADDR_W-1:0] addr_q; // Latched address.
    logic [31:0] hrdata_q; // Registered read data.

    // Bus decode.
    wire logic accept;
    wire logic wr_en;
    wire logic busy;
    wire logic start;
    wire logic [31:0] rd_mux;
    wire logic [31:0] cap_word;
    wire logic [31:0] req_word;

    // Decoder outputs.
    wire logic d_notp;
    wire logic d_rsvd;
    wire logic d_fault;
    wire logic [63:0] d_next;
    wire logic d_gpa;
    wire logic d_exec;
    wire logic d_user;
    wire logic d_user_wr;
    wire logic d_sup_wr;
    wire logic [1:0] d_mt;
    wire logic [63:0] d_upd;
    wire logic d_needs_upd;

    // Events of a finished walk.
    wire logic ev_done;
    wire logic ev_fault;
    wire logic [flw_pkg::INT_W-1:0] int_set;
    wire logic [flw_pkg::INT_W-1:0] int_clr;

    // Walker outcome flops; the ports read them straight.
    logic valid_q;
    logic fault_q;
    logic [63:0] next_q;

    // Returns an address decode for one register address.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    // Only address phases that the bus says are real are taken.
    assign accept = hsel & htrans[1] & hready;
    assign wr_en = wr_pend_q;
    assign busy = (state_q != flw_pkg::ST_IDLE);
    // A start while busy is dropped so a walk is never disturbed midway.
    assign start = wr_en & hit(addr_q, flw_pkg::REG_REQ) &
        hwdata[flw_pkg::RQ_START] & ~busy;

    assign cap_word = {30'h0, HUGE_PAGES, EXT_ACC_SUP};
    assign req_word = {busy, 22'h0, index_q};
    assign huge_page_support = HUGE_PAGES;

    // Read multiplexer; unmapped offsets read as zero.
    assign rd_mux =
        hit(addr_q, flw_pkg::REG_CTRL) ? {27'h0, ctrl_q} :
        hit(addr_q, flw_pkg::REG_CAP) ? cap_word :
        hit(addr_q, flw_pkg::REG_ROOT_LO) ? root_q[31:0] :
        hit(addr_q, flw_pkg::REG_ROOT_HI) ? root_q[63:32] :
        hit(addr_q, flw_pkg::REG_REQ) ? req_word :
        hit(addr_q, flw_pkg::REG_RESULT) ? result_q :
        hit(addr_q, flw_pkg::REG_NEXT_LO) ? next_q[31:0] :
        hit(addr_q, flw_pkg::REG_NEXT_HI) ? next_q[63:32] :
        hit(addr_q, flw_pkg::REG_INT_STATUS) ? {30'h0, int_status_q} :
        hit(addr_q, flw_pkg::REG_INT_MASK) ? {30'h0, int_mask_q} :
        32'h0;

    // A read costs one wait state so it always sees the write before it.
    assign hreadyout = ~rd_pend_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Bus pipeline: latch the address phase, then serve the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata_q <= 32'h0;
        end else begin
            wr_pend_q <= accept & hwrite;
            rd_pend_q <= accept & ~hwrite;
            if (accept) begin
                addr_q <= haddr[flw_pkg::ADDR_W-1:0];
            end
            if (rd_pend_q) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // Software-written configuration registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= flw_pkg::CTRL_RESET;
            root_q <= 64'h0;
            index_q <= 9'h000;
            int_mask_q <= 2'h0;
        end else if (wr_en) begin
            if (hit(addr_q, flw_pkg::REG_CTRL)) begin
                ctrl_q <= hwdata[flw_pkg::CTRL_W-1:0];
            end
            if (hit(addr_q, flw_pkg::REG_ROOT_LO)) begin
                root_q[31:0] <= {hwdata[31:flw_pkg::ROOT_LO_BIT], 7'h00,
                    hwdata[flw_pkg::EB_CDIS:flw_pkg::EB_WTHRU], 3'h0};
            end
            if (hit(addr_q, flw_pkg::REG_ROOT_HI)) begin
                root_q[63:32] <= hwdata;
            end
            if (start) begin
                index_q <= hwdata[flw_pkg::RQ_INDEX_W-1:0];
            end
            if (hit(addr_q, flw_pkg::REG_INT_MASK)) begin
                int_mask_q <= hwdata[flw_pkg::INT_W-1:0];
            end
        end
    end

    // Entry decoder on the captured entry.
    flw_entry_decode #(
        .ADDR_WIDTH(ADDR_WIDTH)
    ) u_decode (
        .entry(entry_q),
        .ext_sup(EXT_ACC_SUP),
        .ext_en(ctrl_q[flw_pkg::CB_EXT_EN]),
        .noexec_en(ctrl_q[flw_pkg::CB_NOEXEC]),
        .nested_en(ctrl_q[flw_pkg::CB_NESTED]),
        .sup_wp_en(ctrl_q[flw_pkg::CB_SUP_WP]),
        .coherent(ctrl_q[flw_pkg::CB_COHERENT]),
        .not_present(d_notp),
        .rsvd_fault(d_rsvd),
        .fault(d_fault),
        .next_addr(d_next),
        .guest_phys(d_gpa),
        .exec_ok(d_exec),
        .user_ok(d_user),
        .user_wr_ok(d_user_wr),
        .sup_wr_ok(d_sup_wr),
        .mem_type(d_mt),
        .upd_entry(d_upd),
        .needs_update(d_needs_upd)
    );

    // Walker sequence: locked fetch, decode, optional write-back, finish.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            flw_pkg::ST_IDLE: begin
                if (start) begin
                    state_d = flw_pkg::ST_FETCH;
                end
            end
            flw_pkg::ST_FETCH: begin
                if (mem_ack) begin
                    state_d = flw_pkg::ST_DECODE;
                end
            end
            flw_pkg::ST_DECODE: begin
                if (!d_fault && d_needs_upd) begin
                    state_d = flw_pkg::ST_WRITE;
                end else begin
                    state_d = flw_pkg::ST_FINISH;
                end
            end
            flw_pkg::ST_WRITE: begin
                if (mem_ack) begin
                    state_d = flw_pkg::ST_FINISH;
                end
            end
            flw_pkg::ST_FINISH: begin
                state_d = flw_pkg::ST_IDLE;
            end
            default: begin
                state_d = flw_pkg::ST_IDLE;
            end
        endcase
    end

    // Memory handshake; the lock spans the read and its write-back.
    assign mem_req = (state_q == flw_pkg::ST_FETCH) |
        (state_q == flw_pkg::ST_WRITE);
    assign mem_we = (state_q == flw_pkg::ST_WRITE);
    assign mem_lock = mem_req | (state_q == flw_pkg::ST_DECODE);

    // Walker state, entry capture and memory address and data flops.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= flw_pkg::ST_IDLE;
            entry_q <= 64'h0;
            mem_addr <= 64'h0;
            mem_wdata <= 64'h0;
            mem_type <= 2'h0;
        end else begin
            state_q <= state_d;
            if (start) begin
                mem_addr <= {root_q[63:flw_pkg::ROOT_LO_BIT], 12'h000} |
                    {52'h0, hwdata[flw_pkg::RQ_INDEX_W-1:0], 3'h0};
                mem_type <= ctrl_q[flw_pkg::CB_COHERENT] ?
                    root_q[flw_pkg::EB_CDIS:flw_pkg::EB_WTHRU] :
                    flw_pkg::MT_DEFAULT;
            end
            if (state_q == flw_pkg::ST_FETCH && mem_ack) begin
                entry_q <= mem_rdata;
            end
            if (state_q == flw_pkg::ST_DECODE) begin
                mem_wdata <= d_upd;
            end
        end
    end

    assign ev_done = (state_q == flw_pkg::ST_FINISH);
    assign ev_fault = ev_done & d_fault;

    // Outcome registers, loaded once per walk as it finishes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_q <= 32'h0;
            next_q <= 64'h0;
            valid_q <= 1'b0;
            fault_q <= 1'b0;
            next_is_guest_phys <= 1'b0;
            next_mem_type <= 2'h0;
            perm_exec <= 1'b0;
            perm_user <= 1'b0;
            perm_user_write <= 1'b0;
            perm_sup_write <= 1'b0;
        end else begin
            valid_q <= ev_done;
            if (ev_done) begin
                fault_q <= d_fault;
                next_q <= d_fault ? 64'h0 : d_next;
                next_is_guest_phys <= d_gpa;
                next_mem_type <= d_mt;
                perm_exec <= d_exec & ~d_fault;
                perm_user <= d_user & ~d_fault;
                perm_user_write <= d_user_wr & ~d_fault;
                perm_sup_write <= d_sup_wr & ~d_fault;
                result_q <= {21'h0, d_notp, d_rsvd, d_gpa, d_mt,
                    d_sup_wr & ~d_fault, d_user_wr & ~d_fault,
                    d_user & ~d_fault, d_exec & ~d_fault, d_fault, 1'b1};
            end
        end
    end

    assign walk_valid = valid_q;
    assign walk_fault = fault_q;
    assign next_table_addr = next_q;

    // Sticky events; a new event wins over a clear in the same cycle.
    assign int_set = {ev_fault, ev_done};
    assign int_clr = (wr_en && hit(addr_q, flw_pkg::REG_INT_STATUS)) ?
        hwdata[flw_pkg::INT_W-1:0] : 2'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_status_q <= 2'h0;
            irq <= 1'b0;
        end else begin
            int_status_q <= (int_status_q & ~int_clr) | int_set;
            irq <= |(((int_status_q & ~int_clr) | int_set) & int_mask_q);
        end
    end

endmodule // flw_top_entry_walker
`default_nettype wire

// file: pkg/flw_pkg.sv
// Constants shared by the top-level entry walker and its entry decoder.
// Assumes a 64-bit paging entry and an AHB-Lite register window of 256 bytes.
package flw_pkg;

    // Register byte offsets inside the AHB window.
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CAP = 8'h04;
    localparam logic [7:0] REG_ROOT_LO = 8'h08;
    localparam logic [7:0] REG_ROOT_HI = 8'h0c;
    localparam logic [7:0] REG_REQ = 8'h10;
    localparam logic [7:0] REG_RESULT = 8'h14;
    localparam logic [7:0] REG_NEXT_LO = 8'h18;
    localparam logic [7:0] REG_NEXT_HI = 8'h1c;
    localparam logic [7:0] REG_INT_STATUS = 8'h20;
    localparam logic [7:0] REG_INT_MASK = 8'h24;

    // Control register fields.
    localparam int CB_EXT_EN = 0;
    localparam int CB_NOEXEC = 1;
    localparam int CB_NESTED = 2;
    localparam int CB_SUP_WP = 3;
    localparam int CB_COHERENT = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // Capability register fields.
    localparam int CAPB_EXT_SUP = 0;
    localparam int CAPB_HUGE = 1;

    // Request register fields.
    localparam int RQ_INDEX_W = 9;
    localparam int RQ_START = 16;
    localparam int RQ_BUSY = 31;

    // Result register fields.
    localparam int RS_VALID = 0;
    localparam int RS_FAULT = 1;
    localparam int RS_EXEC = 2;
    localparam int RS_USER = 3;
    localparam int RS_USER_WR = 4;
    localparam int RS_SUP_WR = 5;
    localparam int RS_MT_LO = 6;
    localparam int RS_GPA = 8;
    localparam int RS_RSVD = 9;
    localparam int RS_NOTP = 10;

    // Interrupt status and mask fields.
    localparam int IB_DONE = 0;
    localparam int IB_FAULT = 1;
    localparam int INT_W = 2;

    // Top-level entry bit positions.
    localparam int EB_PRESENT = 0;
    localparam int EB_RW = 1;
    localparam int EB_US = 2;
    localparam int EB_WTHRU = 3;
    localparam int EB_CDIS = 4;
    localparam int EB_ACC = 5;
    localparam int EB_RSVD7 = 7;
    localparam int EB_EXT_ACC = 10;
    localparam int EB_ADDR_LO = 12;
    localparam int EB_RSVD_HI = 51;
    localparam int EB_NOEXEC = 63;

    // Root pointer fields, and the byte shift of one 8-byte entry.
    localparam int ROOT_LO_BIT = 12;
    localparam int ENTRY_SHIFT = 3;

    // Memory type used when the requester is outside the coherency domain.
    localparam logic [1:0] MT_DEFAULT = 2'h0;

    // Walker states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH = 3'h1,
        ST_DECODE = 3'h2,
        ST_WRITE = 3'h3,
        ST_FINISH = 3'h4
    } flw_state_t;

endpackage

// file: rtl/flw_entry_decode.sv
// Combinational decoder of one top-level paging entry.
// Assumes the entry and the context controls are stable while it is read.
`timescale 1ns/1ps
`default_nettype none
module flw_entry_decode #(
    parameter int ADDR_WIDTH = 48
) (
    input wire logic [63:0] entry,
    input wire logic ext_sup,
    input wire logic ext_en,
    input wire logic noexec_en,
    input wire logic nested_en,
    input wire logic sup_wp_en,
    input wire logic coherent,
    output logic not_present,
    output logic rsvd_fault,
    output logic fault,
    output logic [63:0] next_addr,
    output logic guest_phys,
    output logic exec_ok,
    output logic user_ok,
    output logic user_wr_ok,
    output logic sup_wr_ok,
    output logic [1:0] mem_type,
    output logic [63:0] upd_entry,
    output logic needs_update
);

    // Builds the mask of bits that must be zero for this address width.
    function automatic logic [63:0] rsvd_mask(input int aw);
        logic [63:0] m;
        m = '0;
        for (int i = 0; i < 64; i++) begin
            m[i] = ((i >= aw) && (i <= flw_pkg::EB_RSVD_HI)) ||
                   (i == flw_pkg::EB_RSVD7);
        end
        return m;
    endfunction

    // Builds the mask of the next-table address bits.
    function automatic logic [63:0] addr_mask(input int aw);
        logic [63:0] m;
        m = '0;
        for (int i = 0; i < 64; i++) begin
            m[i] = (i >= flw_pkg::EB_ADDR_LO) && (i < aw);
        end
        return m;
    endfunction

    localparam logic [63:0] RSVD_MASK = rsvd_mask(ADDR_WIDTH);
    localparam logic [63:0] ADDR_MASK = addr_mask(ADDR_WIDTH);

    // The extended-accessed flag counts only when supported and enabled.
    wire logic ext_active;

    assign ext_active = ext_sup & ext_en;

    assign not_present = ~entry[flw_pkg::EB_PRESENT];
    assign rsvd_fault = |(entry & RSVD_MASK);
    assign fault = not_present | rsvd_fault;

    assign next_addr = entry & ADDR_MASK;
    assign guest_phys = nested_en;
    assign exec_ok = ~(noexec_en & entry[flw_pkg::EB_NOEXEC]);
    assign user_ok = entry[flw_pkg::EB_US];
    assign user_wr_ok = entry[flw_pkg::EB_RW];
    assign sup_wr_ok = entry[flw_pkg::EB_RW] | ~sup_wp_en;
    assign mem_type = coherent ?
        {entry[flw_pkg::EB_CDIS], entry[flw_pkg::EB_WTHRU]} :
        flw_pkg::MT_DEFAULT;

    assign upd_entry = entry | (64'h1 << flw_pkg::EB_ACC) |
        ({63'h0, ext_active} << flw_pkg::EB_EXT_ACC);
    assign needs_update = (upd_entry != entry);

endmodule // flw_entry_decode
`default_nettype wire

// file: verif/flw_mem_model.sv
// Memory model that answers the walker's entry fetches and write-backs.
// Assumes one request at a time, held high by the walker until acked.
`timescale 1ns/1ps
`default_nettype none
module flw_mem_model (
    input wire logic clk,
    input wire logic req,
    input wire logic [63:0] entry,
    input wire logic [3:0] lat,
    output logic [63:0] rdata,
    output logic ack
);
    // Wait counter, so the bench can answer promptly or slowly.
    logic [3:0] cnt_q;

    initial begin
        rdata = 64'h0;
        ack = 1'b0;
        cnt_q = 4'h0;
    end

    // Read data toggles outside the ack cycle, so stale data never passes.
    always @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        cnt_q <= 4'h0;
        if (req && !ack) begin
            if (cnt_q >= lat) begin
                ack <= 1'b1;
                rdata <= entry;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule // flw_mem_model
`default_nettype wire

// file: verif/flw_top_entry_walker_assertions.sv
// Checker of the walker's memory port and walk results.
// Assumes binding into the walker, one clock, reset active low.
`timescale 1ns/1ps
`default_nettype none
module flw_checker #(
    parameter int ADDR_WIDTH = 48,
    parameter logic HUGE_PAGES = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_lock,
    input wire logic mem_ack,
    input wire logic [63:0] mem_addr,
    input wire logic [63:0] mem_wdata,
    input wire logic walk_valid,
    input wire logic walk_fault,
    input wire logic [63:0] next_table_addr,
    input wire logic perm_exec,
    input wire logic perm_user,
    input wire logic perm_user_write,
    input wire logic perm_sup_write,
    input wire logic huge_page_support
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_FAULT_PERMS: assert property (walk_valid && walk_fault |->
        !perm_exec && !perm_user && !perm_user_write && !perm_sup_write
        && next_table_addr == 64'h0) else $error("fault kept permissions");
    AST_NEXT_ALIGN: assert property (walk_valid && !walk_fault |->
        next_table_addr[11:0] == 12'h0
        && next_table_addr[63:ADDR_WIDTH] == '0)
        else $error("next table address misaligned");
    AST_SUP_WRITE: assert property (walk_valid && perm_user_write |->
        perm_sup_write) else $error("user write without supervisor write");
    AST_RMW_LOCK: assert property (mem_req && mem_we |-> mem_lock
        && $past(mem_lock) && $past(mem_lock, 2))
        else $error("write-back not inside locked access");
    AST_WB_ACCESSED: assert property (mem_req && mem_we |->
        mem_wdata[5]) else $error("write-back lacks accessed flag");
    AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req
        && $stable(mem_addr) && $stable(mem_wdata))
        else $error("memory request dropped or changed");
    AST_WB_DONE: assert property (mem_req && mem_we && mem_ack |->
        ##2 walk_valid && !walk_fault) else $error("walk end after write");
    AST_HOLD: assert property (!walk_valid |-> $stable(perm_exec)
        && $stable(perm_user) && $stable(next_table_addr))
        else $error("result changed between walks");
    AST_HUGE: assert property (huge_page_support == HUGE_PAGES)
        else $error("huge page capability wrong");
endmodule // flw_checker
bind flw_top_entry_walker flw_checker #(.ADDR_WIDTH(ADDR_WIDTH),
    .HUGE_PAGES(HUGE_PAGES))
    i_chk (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_lock(mem_lock), .mem_ack(mem_ack),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .walk_valid(walk_valid),
    .walk_fault(walk_fault), .next_table_addr(next_table_addr),
    .perm_exec(perm_exec), .perm_user(perm_user),
    .perm_user_write(perm_user_write), .perm_sup_write(perm_sup_write),
    .huge_page_support(huge_page_support));
`default_nettype wire

// file: verif/flw_top_entry_walker_tb.sv
// Bench of the walker: random entries and controls against a memory model.
// Assumes AHB reads take one wait state and writes none.
`timescale 1ns/1ps
`default_nettype none
module flw_top_entry_walker_tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, rph;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, mem_type, next_mem_type, fmt;
    logic [2:0] hsize;
    logic [3:0] lat;
    logic mem_req, mem_we, mem_lock, mem_ack, walk_valid, walk_fault;
    logic next_is_guest_phys, perm_exec, perm_user, perm_user_write;
    logic perm_sup_write, huge_page_support;
    logic [63:0] mem_addr, mem_wdata, mem_rdata, next_table_addr, ent, fa;
    int err_total, checks_done;
    // Expected walk results, write-backs and read data, oldest first.
    logic [138:0] wq[$];
    logic [127:0] bq[$];
    logic [31:0] rq[$];

    flw_top_entry_walker #(.ADDR_WIDTH(48)) i_dut (.hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .mem_req(mem_req), .mem_we(mem_we), .mem_lock(mem_lock),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_type(mem_type),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .walk_valid(walk_valid),
        .walk_fault(walk_fault), .next_table_addr(next_table_addr),
        .next_is_guest_phys(next_is_guest_phys),
        .next_mem_type(next_mem_type), .perm_exec(perm_exec),
        .perm_user(perm_user), .perm_user_write(perm_user_write),
        .perm_sup_write(perm_sup_write),
        .huge_page_support(huge_page_support));
    flw_mem_model i_mem (.clk(hclk), .req(mem_req), .entry(ent), .lat(lat),
        .rdata(mem_rdata), .ack(mem_ack));

    always #2 hclk = ~hclk;

    task automatic test_done();
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp(input logic [138:0] g, input logic [138:0] x);
        checks_done++;
        if (g !== x) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, g, x);
        end
    endtask

    task automatic chk_rd();
        if (rq.size() == 0) cmp(1, 0);
        else cmp({hresp, hrdata}, {1'b0, rq.pop_front()});
    endtask

    task automatic chk_wb();
        if (bq.size() == 0) cmp(1, 0);
        else cmp({mem_addr, mem_wdata}, bq.pop_front());
    endtask

    // On a fault the next-table type and kind carry no meaning.
    task automatic chk_walk();
        logic [138:0] g;
        logic [138:0] x;
        g = {fa, fmt, irq, walk_fault, next_is_guest_phys, next_mem_type,
            perm_exec, perm_user, perm_user_write, perm_sup_write,
            next_table_addr};
        x = wq.size() ? wq.pop_front() : ~g;
        if (x[71]) g[70:68] = x[70:68];
        cmp(g, x);
    endtask

    // One single AHB transfer; the master waits on ready at every phase.
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        rq.push_back(x);
        ahb(1'b0, a, 32'h0);
    endtask

    // One random walk, with a start refused while busy.
    task automatic walk();
        logic [4:0] c;
        logic [8:0] ix;
        logic [1:0] m;
        logic [63:0] e, r, u;
        logic f, co;
        c = 5'($urandom);
        ix = 9'($urandom);
        m = 2'($urandom);
        e = {$urandom, $urandom};
        r = {$urandom, $urandom};
        // software keeps the root inside the address width
        r[63:48] = 16'h0;
        if ($urandom % 4 != 0) e[51:48] = 4'h0;
        if ($urandom % 4 != 0) e[7] = 1'b0;
        if ($urandom % 6 != 0) e[0] = 1'b1;
        f = !e[0] || e[7] || e[51:48] != 4'h0;
        co = c[flw_pkg::CB_COHERENT];
        u = e | 64'h20 | (c[0] ? 64'h400 : 64'h0);
        ent <= e;
        lat <= 4'($urandom % 5);
        ahb(1'b1, flw_pkg::REG_CTRL, {27'h0, c});
        ahb(1'b1, flw_pkg::REG_INT_MASK, {30'h0, m});
        ahb(1'b1, flw_pkg::REG_ROOT_LO, r[31:0]);
        ahb(1'b1, flw_pkg::REG_ROOT_HI, r[63:32]);
        rd(flw_pkg::REG_ROOT_LO, r[31:0] & 32'hfffff018);
        wq.push_back({r[63:12], ix, 3'h0, co ? r[4:3] : 2'h0,
            |(m & {f, 1'b1}), f, c[2], co ? e[4:3] : 2'h0,
            f ? 4'h0 : {!(c[1] && e[63]), e[2], e[1], e[1] || !c[3]},
            f ? 64'h0 : {16'h0, e[47:12], 12'h0}});
        if (!f && u != e) bq.push_back({r[63:12], ix, 3'h0, u});
        ahb(1'b1, flw_pkg::REG_REQ, 32'h10000 | {23'h0, ix});
        ahb(1'b1, flw_pkg::REG_REQ, 32'h10000 | {23'h0, ~ix});
        for (int k = 0; k < 200 && !walk_valid; k++) @(posedge hclk);
        rd(flw_pkg::REG_INT_STATUS, {30'h0, f, 1'b1});
        ahb(1'b1, flw_pkg::REG_INT_STATUS, 32'h3);
        rd(flw_pkg::REG_INT_STATUS, 32'h0);
    endtask

    // Result watcher: fetch address, write-backs, walk ends, read data.
    always @(posedge hclk) begin
        if (mem_ack && !mem_we) begin
            fa = mem_addr;
            fmt = mem_type;
        end
        if (mem_ack && mem_we) chk_wb();
        if (walk_valid) chk_walk();
        if (rph && hreadyout) chk_rd();
        if (hreadyout) rph = htrans[1] && !hwrite;
    end

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ent = 64'h0;
        lat = 4'h0;
        rph = 1'b0;
        void'($urandom(32'h6e75));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(flw_pkg::REG_CAP, 32'h3);
        ahb(1'b1, flw_pkg::REG_CAP, 32'h0);
        ahb(1'b1, 8'h40, 32'hffffffff);
        rd(8'h40, 32'h0);
        rd(flw_pkg::REG_CAP, 32'h3);
        for (int i = 0; i < 40; i++) walk();
        repeat (2) @(posedge hclk);
        if (wq.size() + bq.size() + rq.size() != 0) cmp(1, 0);
        test_done();
    end

    // Forty walks take under about 1500 cycles; this bound of 25000 cycles is far beyond.
    initial begin
        #100000;
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        test_done();
    end
endmodule // flw_top_entry_walker_tb
`default_nettype wire
